// ==== ext_mem_model.sv ====
/* external program, data and boot memory seen from the pins.
   assumes the design's enables resolve the data lines here. */
`timescale 1ns/1ps
module ext_mem_model (
  // pins from the design
  input wire logic mclk,
  input wire logic [13:0] addr_out,
  input wire logic [23:0] data_out,
  input wire logic [23:0] data_oe,
  input wire logic program_memory_select_n,
  input wire logic data_memory_select_n,
  input wire logic boot_memory_select_n,
  input wire logic rd_n,
  input wire logic wr_n,
  // resolved data lines
  output logic [23:0] data_in
);
  logic [23:0] mem [0:255]; // shared word store
  logic [23:0] junk = 24'h5a5a5a; // released lines toggle
  logic [23:0] q;
  // store on a write strobe with the program or data select low
  always @(posedge mclk) begin
    junk <= ~junk;
    if (!wr_n && !(program_memory_select_n && data_memory_select_n))
      mem[addr_out[7:0]] <= data_out;
  end
  // answers; the boot device drives d15:d8 only
  always_comb begin
    q = junk;
    if (!rd_n && !(program_memory_select_n && data_memory_select_n))
      q = mem[addr_out[7:0]];
    if (!rd_n && !boot_memory_select_n)
      q[15:8] = addr_out[7:0] ^ {data_out[23:22], addr_out[13:8]};
    data_in = (data_out & data_oe) | (q & ~data_oe);
  end
endmodule

// ==== ext_mem_pkg.sv ====
/*
 * constants and types for the external memory and boot interface.
 * assumes a 14-bit address bus, a 24-bit data bus and one processor clock.
 */
package ext_mem_pkg;
  // widths
  localparam int ADDR_W = 14;
  localparam int DATA_W = 24;
  localparam int DM_W = 16;
  localparam int PX_W = 8;
  localparam int WAIT_W = 3;
  localparam int PAGE_W = 3;
  localparam int ZONES = 5;
  localparam int MODE_STATUS_REG_W = 7;
  localparam int IRQ_W = 3;
  localparam int LARGE_OFS_W = 13;
  localparam int SMALL_OFS_W = 12;
  // reset values
  localparam logic [2:0] PM_WAITS_RST = 3'h7;
  localparam logic [2:0] DM_WAITS_RST = 3'h7;
  localparam logic [2:0] BOOT_WAITS_RST = 3'h3;
  localparam logic [2:0] BOOT_PAGE_RST = 3'h0;
  localparam logic [6:0] MODE_STATUS_REG_RST = 7'h00;
  localparam logic [10:0] PM_RESET_VECTOR = 11'h000;
  // program memory map
  localparam logic [13:0] PM_EXT_BASE = 14'h0800;
  localparam logic [13:0] SMALL_PM_RAM_END = 14'h0400;
  localparam logic [13:0] PM_HIGH_RAM_BASE = 14'h3800;
  localparam logic [13:0] SMALL_PM_HIGH_TOP = 14'h3bff;
  // data memory map
  localparam logic [13:0] DM_ONCHIP_BASE = 14'h3800;
  localparam logic [13:0] DM_REGS_LARGE = 14'h3c00;
  localparam logic [13:0] DM_REGS_SMALL = 14'h3a00;
  // external data memory zone bases
  localparam logic [13:0] ZONE1_BASE = 14'h0400;
  localparam logic [13:0] ZONE2_BASE = 14'h0800;
  localparam logic [13:0] ZONE3_BASE = 14'h2000;
  localparam logic [13:0] ZONE4_BASE = 14'h3000;
  // boot loader
  localparam logic [1:0] LAST_BYTE_IDX = 2'h2;
  localparam logic [10:0] LARGE_LAST_WORD = 11'h7ff;
  localparam logic [10:0] SMALL_LAST_WORD = 11'h3ff;
  localparam logic [23:0] BOOT_OE_MASK = 24'hc00000;
  localparam logic [2:0] SETTLE_CYCLES = 3'h5;
  // bus sequencer states, gray along idle-strobe-idle and idle-grant
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STROBE = 2'b01,
    ST_GRANT = 2'b10
  } bus_state_t;
  typedef enum logic [1:0] {
    SP_PM = 2'b00,
    SP_DM = 2'b01,
    SP_BOOT = 2'b10
  } space_t;
endpackage

// ==== external_memory_boot_interface.sv ====
/*
 * external memory interface with byte-wide boot loader.
 * assumes the core holds core_req and its fields until core_done,
 * and that external pins are resolved from the enables by the testbench.
 */
// Summary of operation
// - reset empties stacks, masks interrupts, clears status
// - boot on release if no request, map low
// - one 24-bit data, 14-bit address bus shared
// - program select with read and write strobes
// - extension register supplies/receives low program byte
// - program waits zero to seven, reset seven
// - large map low: ram 0x0000, external 0x0800
// - map high: external low, ram from 0x3800
// - small variant ram 1K, high at 0x3800-0x3bff
// - data words on upper sixteen data lines
// - data select with strobe, peripherals alike
// - large data ram 0x3800, registers from 0x3c00
// - small data ram 512, registers from 0x3a00
// - five data zones, own waits, reset seven
// - boot space eight pages, 8K or 4K
// - boot bytes packed into 24-bit words
// - three-bit page field, page zero after reset
// - force bit starts boot under software
// - boot waits zero to seven, reset three
// - boot select, read strobe, bytes on D8-D15
// - page on top data lines, top address
// - boot grants bus only between bytes
// - access completes, grant follows next cycle
`timescale 1ns/1ps
module external_memory_boot_interface #(
  parameter bit LARGE = 1'b1 // 1: 2K program ram variant, 0: 1K variant
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // straps and arbitration pins
  input wire logic map_select_pin,
  input wire logic bus_request_n,
  output logic bus_grant_n,
  // external memory pins
  output logic [13:0] addr_out,
  output logic addr_oe,
  input wire logic [23:0] data_in,
  output logic [23:0] data_out,
  output logic [23:0] data_oe,
  output logic program_memory_select_n,
  output logic data_memory_select_n,
  output logic boot_memory_select_n,
  output logic rd_n,
  output logic wr_n,
  output logic ctrl_oe,
  // core access port
  input wire logic core_req,
  input wire logic core_dm,
  input wire logic core_we,
  input wire logic core_pm16,
  input wire logic [13:0] core_addr,
  input wire logic [23:0] core_wdata,
  output logic core_done,
  output logic [23:0] core_rdata,
  output logic pm_ram_hit,
  output logic dm_ram_hit,
  output logic dm_regs_hit,
  // core state registers
  input wire logic px_wr,
  input wire logic [7:0] px_wdata,
  output logic [7:0] program_extension_reg,
  input wire logic mode_status_reg_wr,
  input wire logic [6:0] mode_status_reg_wdata,
  output logic [6:0] mode_status_reg,
  input wire logic irq_wr,
  input wire logic [2:0] irq_wdata,
  output logic [2:0] irq_enable,
  output logic stack_flush,
  // system control and wait-state configuration
  input wire logic sysctl_wr,
  input wire logic [2:0] sysctl_page,
  input wire logic sysctl_force_boot,
  input wire logic [2:0] sysctl_boot_waits,
  input wire logic [2:0] sysctl_pm_waits,
  input wire logic dm_waits_wr,
  input wire logic [14:0] dm_waits_data,
  // boot loader to on-chip program memory
  output logic boot_wr,
  output logic [10:0] boot_word_addr,
  output logic [23:0] boot_word,
  output logic booting
);
  wait_state_if ws (); // timer handshake
  ext_mem_pkg::bus_state_t state; // sequencer state
  ext_mem_pkg::bus_state_t next_state;
  ext_mem_pkg::space_t acc_space; // space of access in flight
  logic acc_we; // access in flight is a write
  logic acc_pm16; // 16-bit program memory access
  logic [2:0] br_sync; // bus request synchroniser
  logic [2:0] map_sync; // map strap synchroniser
  logic br_active; // agreed bus request level
  logic map_level; // agreed map strap level
  logic [2:0] settle; // cycles since reset release
  logic ready; // synchronisers settled
  logic take_core; // open a core access this cycle
  logic take_boot; // open a boot byte read this cycle
  logic core_ext; // core address leaves the chip
  logic [2:0] boot_page; // page to load
  logic [2:0] boot_waits; // boot read wait states
  logic [2:0] pm_waits; // program memory wait states
  logic [2:0] dm_waits [ext_mem_pkg::ZONES]; // per-zone wait states
  logic [2:0] next_waits; // wait states for the new access
  logic [1:0] byte_idx; // byte within boot word
  logic [12:0] boot_ofs; // byte offset in boot page
  logic [15:0] boot_shift; // bytes gathered so far
  logic [10:0] last_word; // last word of on-chip ram
  logic [3:0] strobe_cnt; // helper: cycles of current strobe
  logic [2:0] act_waits; // helper: wait states of current access

  // shared wait-state timer
  wait_state_timer u_timer (
    .mclk(mclk),
    .resetn(resetn),
    .ws(ws)
  );

  // program map: on-chip window and populated ram
  function automatic logic pm_window(input logic [13:0] a, input logic mm);
    return mm ? (a >= ext_mem_pkg::PM_HIGH_RAM_BASE) : (a < ext_mem_pkg::PM_EXT_BASE);
  endfunction

  function automatic logic pm_ram(input logic [13:0] a, input logic mm);
    logic hit;
    hit = 1'b0;
    if (LARGE) begin
      hit = pm_window(a, mm);
    end else if (!mm) begin
      hit = (a < ext_mem_pkg::SMALL_PM_RAM_END);
    end else begin
      hit = (a >= ext_mem_pkg::PM_HIGH_RAM_BASE) && (a <= ext_mem_pkg::SMALL_PM_HIGH_TOP);
    end
    return hit;
  endfunction

  // external data zone of an address
  function automatic logic [2:0] dm_zone(input logic [13:0] a);
    logic [2:0] z;
    z = 3'h0;
    if (a >= ext_mem_pkg::ZONE4_BASE) begin
      z = 3'h4;
    end else if (a >= ext_mem_pkg::ZONE3_BASE) begin
      z = 3'h3;
    end else if (a >= ext_mem_pkg::ZONE2_BASE) begin
      z = 3'h2;
    end else if (a >= ext_mem_pkg::ZONE1_BASE) begin
      z = 3'h1;
    end
    return z;
  endfunction

  // strap and request pins: three stages, change counts when last two agree
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      br_sync <= 3'h7;
      map_sync <= 3'h0;
      br_active <= 1'b0;
      map_level <= 1'b0;
    end else begin
      br_sync <= {br_sync[1:0], bus_request_n};
      map_sync <= {map_sync[1:0], map_select_pin};
      if (br_sync[1] == br_sync[2]) begin
        br_active <= !br_sync[2];
      end
      if (map_sync[1] == map_sync[2]) begin
        map_level <= map_sync[2];
      end
    end
  end

  // wait for the synchronisers to fill after release
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      settle <= 3'h0;
      ready <= 1'b0;
    end else if (!ready) begin
      settle <= settle + 3'h1;
      ready <= (settle == ext_mem_pkg::SETTLE_CYCLES);
    end
  end

  // core state cleared by reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stack_flush <= 1'b1;
      mode_status_reg <= ext_mem_pkg::MODE_STATUS_REG_RST;
      irq_enable <= 3'h0;
    end else begin
      stack_flush <= 1'b0;
      if (mode_status_reg_wr) begin
        mode_status_reg <= mode_status_reg_wdata;
      end
      if (irq_wr) begin
        irq_enable <= irq_wdata;
      end
    end
  end

  // system control and wait-state configuration
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      boot_page <= ext_mem_pkg::BOOT_PAGE_RST;
      boot_waits <= ext_mem_pkg::BOOT_WAITS_RST;
      pm_waits <= ext_mem_pkg::PM_WAITS_RST;
    end else if (sysctl_wr) begin
      boot_page <= sysctl_page;
      boot_waits <= sysctl_boot_waits;
      pm_waits <= sysctl_pm_waits;
    end
  end

  // one wait-state register per data zone
  for (genvar z = 0; z < ext_mem_pkg::ZONES; z++) begin : g_zone
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        dm_waits[z] <= ext_mem_pkg::DM_WAITS_RST;
      end else if (dm_waits_wr) begin
        dm_waits[z] <= dm_waits_data[3*z +: 3];
      end
    end
  end

  // decode of the core address
  always_comb begin
    if (core_dm) begin
      core_ext = (core_addr < ext_mem_pkg::DM_ONCHIP_BASE);
    end else begin
      core_ext = !pm_window(core_addr, map_level);
    end
  end

  // decode flags for the core's on-chip paths
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pm_ram_hit <= 1'b0;
      dm_ram_hit <= 1'b0;
      dm_regs_hit <= 1'b0;
    end else begin
      pm_ram_hit <= core_req && !core_dm && pm_ram(core_addr, map_level);
      dm_ram_hit <= core_req && core_dm && !core_ext &&
        (core_addr < (LARGE ? ext_mem_pkg::DM_REGS_LARGE : ext_mem_pkg::DM_REGS_SMALL));
      dm_regs_hit <= core_req && core_dm &&
        (core_addr >= (LARGE ? ext_mem_pkg::DM_REGS_LARGE : ext_mem_pkg::DM_REGS_SMALL));
    end
  end

  // sequencer next state; a request waits for the access in flight
  always_comb begin
    next_state = state;
    take_core = 1'b0;
    take_boot = 1'b0;
    case (state)
      ext_mem_pkg::ST_IDLE: begin
        if (br_active) begin
          next_state = ext_mem_pkg::ST_GRANT;
        end else if (booting && !(boot_wr && boot_word_addr == last_word)) begin
          // last word just written: booting drops now, no further byte read
          next_state = ext_mem_pkg::ST_STROBE;
          take_boot = 1'b1;
        end else if (ready && core_req && !core_done && core_ext) begin
          next_state = ext_mem_pkg::ST_STROBE;
          take_core = 1'b1;
        end
      end
      ext_mem_pkg::ST_STROBE: begin
        if (ws.expired) begin
          next_state = ext_mem_pkg::ST_IDLE;
        end
      end
      ext_mem_pkg::ST_GRANT: begin
        if (!br_active) begin
          next_state = ext_mem_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = ext_mem_pkg::ST_IDLE;
      end
    endcase
  end

  // wait states of the access being opened
  always_comb begin
    if (take_boot) begin
      next_waits = boot_waits;
    end else if (core_dm) begin
      next_waits = dm_waits[dm_zone(core_addr)];
    end else begin
      next_waits = pm_waits;
    end
  end
  assign ws.load = take_core || take_boot;
  assign ws.waits = next_waits;

  // sequencer state
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state <= ext_mem_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // kind of access in flight
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      acc_space <= ext_mem_pkg::SP_PM;
      acc_we <= 1'b0;
      acc_pm16 <= 1'b0;
    end else if (take_boot) begin
      acc_space <= ext_mem_pkg::SP_BOOT;
      acc_we <= 1'b0;
      acc_pm16 <= 1'b0;
    end else if (take_core) begin
      acc_space <= core_dm ? ext_mem_pkg::SP_DM : ext_mem_pkg::SP_PM;
      acc_we <= core_we;
      acc_pm16 <= core_pm16 && !core_dm;
    end
  end

  // memory pins: selects, strobes, address and data drive
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      program_memory_select_n <= 1'b1;
      data_memory_select_n <= 1'b1;
      boot_memory_select_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      addr_out <= 14'h0000;
      data_out <= 24'h000000;
      data_oe <= 24'h000000;
    end else if (take_boot) begin
      boot_memory_select_n <= 1'b0;
      rd_n <= 1'b0;
      addr_out[13] <= boot_page[0];
      addr_out[12:0] <= LARGE ? boot_ofs : {1'b0, boot_ofs[11:0]};
      data_out <= {boot_page[2:1], 22'h000000};
      data_oe <= ext_mem_pkg::BOOT_OE_MASK;
    end else if (take_core) begin
      program_memory_select_n <= core_dm;
      data_memory_select_n <= !core_dm;
      rd_n <= core_we;
      wr_n <= !core_we;
      addr_out <= core_addr;
      if (core_dm) begin
        data_out <= {core_wdata[15:0], 8'h00};
      end else if (core_pm16) begin
        data_out <= {core_wdata[15:0], program_extension_reg};
      end else begin
        data_out <= core_wdata;
      end
      data_oe <= core_we ? 24'hffffff : 24'h000000;
    end else if (state == ext_mem_pkg::ST_STROBE && ws.expired) begin
      program_memory_select_n <= 1'b1;
      data_memory_select_n <= 1'b1;
      boot_memory_select_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      data_oe <= 24'h000000;
    end
  end

  // arbitration: release drivers and grant, restore on release
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      bus_grant_n <= 1'b1;
      addr_oe <= 1'b1;
      ctrl_oe <= 1'b1;
    end else if (next_state == ext_mem_pkg::ST_GRANT) begin
      bus_grant_n <= 1'b0;
      addr_oe <= 1'b0;
      ctrl_oe <= 1'b0;
    end else begin
      bus_grant_n <= 1'b1;
      addr_oe <= 1'b1;
      ctrl_oe <= 1'b1;
    end
  end

  // access completion and read data to the core, extension register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      core_done <= 1'b0;
      core_rdata <= 24'h000000;
      program_extension_reg <= 8'h00;
    end else begin
      core_done <= 1'b0;
      if (state == ext_mem_pkg::ST_STROBE && ws.expired && acc_space != ext_mem_pkg::SP_BOOT) begin
        core_done <= 1'b1;
        if (acc_space == ext_mem_pkg::SP_DM || acc_pm16) begin
          core_rdata <= {8'h00, data_in[23:8]};
        end else begin
          core_rdata <= data_in;
        end
        if (acc_pm16 && !acc_we) begin
          program_extension_reg <= data_in[7:0];
        end
      end else if (px_wr) begin
        program_extension_reg <= px_wdata;
      end
    end
  end

  // boot loader: start, byte packing, word writes
  assign last_word = LARGE ? ext_mem_pkg::LARGE_LAST_WORD : ext_mem_pkg::SMALL_LAST_WORD;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      booting <= 1'b0;
      byte_idx <= 2'h0;
      boot_ofs <= 13'h0000;
      boot_shift <= 16'h0000;
      boot_word_addr <= ext_mem_pkg::PM_RESET_VECTOR;
      boot_word <= 24'h000000;
      boot_wr <= 1'b0;
    end else begin
      boot_wr <= 1'b0;
      if (!ready && settle == ext_mem_pkg::SETTLE_CYCLES) begin
        booting <= !map_level && !br_active;
      end else if (sysctl_wr && sysctl_force_boot && !booting) begin
        booting <= 1'b1;
        byte_idx <= 2'h0;
        boot_ofs <= 13'h0000;
        boot_word_addr <= ext_mem_pkg::PM_RESET_VECTOR;
      end else if (state == ext_mem_pkg::ST_STROBE && ws.expired &&
                   acc_space == ext_mem_pkg::SP_BOOT) begin
        boot_ofs <= boot_ofs + 13'h0001;
        if (byte_idx == ext_mem_pkg::LAST_BYTE_IDX) begin
          byte_idx <= 2'h0;
          boot_word <= {boot_shift, data_in[15:8]};
          boot_wr <= 1'b1;
        end else begin
          byte_idx <= byte_idx + 2'h1;
          boot_shift <= {boot_shift[7:0], data_in[15:8]};
        end
      end else if (boot_wr) begin
        if (boot_word_addr == last_word) begin
          booting <= 1'b0;
        end
        boot_word_addr <= boot_word_addr + 11'h001;
      end
    end
  end

  // helper: length of each strobe and its programmed waits
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      strobe_cnt <= 4'h0;
      act_waits <= 3'h0;
    end else begin
      strobe_cnt <= (!rd_n || !wr_n) ? strobe_cnt + 4'h1 : 4'h0;
      if (ws.load) begin
        act_waits <= ws.waits;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_reset_state;
    $rose(resetn) |-> mode_status_reg == 7'h00 && irq_enable == 3'h0 && stack_flush;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
  property p_strobe_len;
    $rose(rd_n && wr_n) |-> strobe_cnt == {1'b0, act_waits} + 4'h1;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");
  property p_pm_strobe;
    !program_memory_select_n |-> (rd_n != wr_n) && data_memory_select_n && boot_memory_select_n;
  endproperty
  a_pm_strobe: assert property (p_pm_strobe) else $error("program strobe wrong");
  property p_dm_strobe;
    !data_memory_select_n |-> (rd_n != wr_n) && program_memory_select_n;
  endproperty
  a_dm_strobe: assert property (p_dm_strobe) else $error("data strobe wrong");
  property p_dm_write_lanes;
    !data_memory_select_n && !wr_n |-> data_out[7:0] == 8'h00 && data_oe == 24'hffffff;
  endproperty
  a_dm_write_lanes: assert property (p_dm_write_lanes) else $error("data lanes wrong");
  property p_boot_pins;
    !boot_memory_select_n |-> !rd_n && wr_n && data_oe == 24'hc00000 &&
      data_out[23:22] == boot_page[2:1] && addr_out[13] == boot_page[0];
  endproperty
  a_boot_pins: assert property (p_boot_pins) else $error("boot pins wrong");
  property p_grant_idle;
    !bus_grant_n |-> program_memory_select_n && data_memory_select_n &&
      boot_memory_select_n && !addr_oe && !ctrl_oe && data_oe == 24'h000000;
  endproperty
  a_grant_idle: assert property (p_grant_idle) else $error("drivers on in grant");
  property p_grant_after_access;
    $fell(bus_grant_n) |-> $past(rd_n) && $past(wr_n);
  endproperty
  a_grant_after_access: assert property (p_grant_after_access) else $error("grant mid access");
  property p_map_high_no_boot;
    $rose(ready) && map_level |=> !booting;
  endproperty
  a_map_high_no_boot: assert property (p_map_high_no_boot) else $error("boot with map high");

  c_boot_word: cover property (boot_wr);
  c_grant: cover property ($fell(bus_grant_n));
  c_pm_read: cover property (!program_memory_select_n && !rd_n ##1 program_memory_select_n);
  c_dm_write: cover property (!data_memory_select_n && !wr_n);
endmodule

// ==== external_memory_boot_interface_test.sv ====
/* self-checking bench for the external memory and boot interface.
   assumes the memory model on the pins and the large variant. */
`timescale 1ns/1ps
module external_memory_boot_interface_test;
  logic mclk = '0, resetn = '0, map_select_pin = '0, bus_request_n = '1, core_req = '0;
  logic core_dm = '0, core_we = '0, core_pm16 = '0, px_wr = '0, sysctl_wr = '0;
  logic sysctl_force_boot = '0, dm_waits_wr = '0, mode_status_reg_wr = '0, irq_wr = '0;
  logic [13:0] core_addr = '0, addr_out;
  logic [23:0] core_wdata = '0, data_in, data_out, data_oe, core_rdata, boot_word, d;
  logic [7:0] px_wdata = '0, program_extension_reg;
  logic [6:0] mode_status_reg_wdata = '0, mode_status_reg;
  logic [2:0] irq_wdata = '0, irq_enable, sysctl_page = '0, sysctl_boot_waits = '0, w;
  logic [2:0] sysctl_pm_waits = '0;
  logic [14:0] dm_waits_data = '0;
  logic [10:0] boot_word_addr;
  logic bus_grant_n, addr_oe, program_memory_select_n, data_memory_select_n;
  logic boot_memory_select_n, rd_n, wr_n, ctrl_oe, core_done, pm_ram_hit, dm_ram_hit;
  logic dm_regs_hit, stack_flush, boot_wr, booting;
  logic [47:0] exp_q [$]; // mask and expected value
  logic [47:0] e;
  logic [13:0] za [5] = '{14'h0000, 14'h0400, 14'h0800, 14'h2000, 14'h3000}; // one per zone
  int mismatches = 0, cmp_count = 0, seed = 19749;
  external_memory_boot_interface external_memory_boot_interface_inst (.*);
  ext_mem_model ext_mem_model_inst (.*);
  initial forever #25 mclk = ~mclk;
  task automatic chk(input logic [23:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // boot byte as the model hands it out
  function automatic logic [7:0] bb(input logic [2:0] p, input logic [12:0] o);
    return o[7:0] ^ {p, o[12:8]};
  endfunction
  task automatic boot_exp(input logic [2:0] p);
    for (int i = 0; i < 2048; i++)
      exp_q.push_back({24'hffffff, bb(p, 13'(3*i)), bb(p, 13'(3*i+1)), bb(p, 13'(3*i+2))});
  endtask
  task automatic wait_boot;
    int n = 0;
    while (booting && n < 40000) begin
      @(negedge mclk);
      n++;
    end
    chk(24'(exp_q.size()), 24'h0);
  endtask
  // k is {dm, write, 16-bit}; w the wait states in force
  task automatic acc(input logic [2:0] k, input logic [13:0] a,
                     input logic [23:0] wd, ex, mk, input logic [2:0] w);
    int n = 0;
    exp_q.push_back({mk, ex});
    {core_dm, core_we, core_pm16, core_addr, core_wdata, core_req} = {k, a, wd, 1'b1};
    do begin
      @(negedge mclk);
      n++;
    end while (!core_done && n < 20);
    chk(24'(n), 24'(w) + 24'h2);
    core_req = '0;
    @(negedge mclk);
  endtask
  task automatic sys(input logic [2:0] pg, bw, pw, input logic fb);
    {sysctl_page, sysctl_boot_waits, sysctl_pm_waits, sysctl_force_boot} = {pg, bw, pw, fb};
    sysctl_wr = '1;
    @(negedge mclk);
    sysctl_wr = '0;
  endtask
  // on-chip address: decode flags and no select
  task automatic onchip(input logic [2:0] k, input logic [13:0] a, input logic [3:0] ex);
    {core_dm, core_we, core_pm16, core_addr, core_req} = {k, a, 1'b1};
    repeat (3) @(negedge mclk);
    chk({dm_ram_hit, dm_regs_hit, pm_ram_hit, program_memory_select_n & data_memory_select_n}, ex);
    core_req = '0;
    @(negedge mclk);
  endtask
  // result watcher: oldest note against each answer
  always @(negedge mclk) begin
    if ((boot_wr || core_done) && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk((boot_wr ? boot_word : core_rdata) & e[47:24], e[23:0]);
      if (boot_wr) chk(24'(boot_word_addr), 24'(2047 - exp_q.size()));
    end
  end
  initial begin
    #4ms;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (3) @(negedge mclk);
    chk({stack_flush, irq_enable, mode_status_reg}, 24'h400);
    boot_exp(3'h0);
    resetn = '1;
    repeat (10) @(negedge mclk);
    chk(booting, 1'h1);
    wait_boot();
    acc(3'h2, 14'h0800, 24'h123456, 24'h0, 24'h0, 3'h7);
    acc(3'h0, 14'h0800, 24'h0, 24'h123456, 24'hffffff, 3'h7);
    for (int i = 0; i < 4; i++) begin
      w = 3'($random(seed));
      d = 24'($random(seed));
      sys(3'h0, 3'h3, w, 1'b0);
      acc(3'h2, 14'h0900 + 14'(i), d, 24'h0, 24'h0, w);
      acc(3'h0, 14'h0900 + 14'(i), 24'h0, d, 24'hffffff, w);
    end
    {px_wr, px_wdata} = {1'b1, 8'h5a};
    @(negedge mclk);
    px_wr = '0;
    acc(3'h3, 14'h0a00, d, 24'h0, 24'h0, w);
    {px_wr, px_wdata} = {1'b1, 8'ha5};
    @(negedge mclk);
    px_wr = '0;
    acc(3'h1, 14'h0a00, 24'h0, {8'h0, d[15:0]}, 24'h00ffff, w);
    chk(program_extension_reg, 8'h5a);
    acc(3'h6, 14'h3000, d, 24'h0, 24'h0, 3'h7);
    {dm_waits_wr, dm_waits_data} = {1'b1, 15'($random(seed))};
    @(negedge mclk);
    dm_waits_wr = '0;
    for (int z = 0; z < 5; z++) begin
      d = 24'($random(seed));
      acc(3'h6, za[z], d, 24'h0, 24'h0, dm_waits_data[3*z+:3]);
      acc(3'h4, za[z], 24'h0, {8'h0, d[15:0]}, 24'h00ffff, dm_waits_data[3*z+:3]);
    end
    onchip(3'h4, 14'h3800, 4'h9);
    onchip(3'h4, 14'h3c00, 4'h5);
    onchip(3'h0, 14'h0000, 4'h3);
    bus_request_n = '0;
    repeat (8) @(negedge mclk);
    chk({bus_grant_n, addr_oe, ctrl_oe}, 3'h0);
    bus_request_n = '1;
    repeat (8) @(negedge mclk);
    chk({bus_grant_n, addr_oe, ctrl_oe}, 3'h7);
    boot_exp(3'h5);
    sys(3'h5, 3'h0, 3'h7, 1'b1);
    repeat (3) @(negedge mclk);
    chk(booting, 1'h1);
    bus_request_n = '0;
    repeat (12) @(negedge mclk);
    chk(bus_grant_n, 1'h0);
    bus_request_n = '1;
    wait_boot();
    {mode_status_reg_wr, mode_status_reg_wdata, irq_wr, irq_wdata} = {1'b1, 7'h55, 1'b1, 3'h5};
    @(negedge mclk);
    {mode_status_reg_wr, irq_wr, map_select_pin, resetn} = 4'h2;
    chk({irq_enable, mode_status_reg}, 24'h2d5);
    @(negedge mclk);
    chk({stack_flush, irq_enable, mode_status_reg}, 24'h400);
    resetn = '1;
    repeat (10) @(negedge mclk);
    chk(booting, 1'h0);
    acc(3'h0, 14'h0000, 24'h0, {d[15:0], 8'h00}, 24'hffffff, 3'h7);
    onchip(3'h0, 14'h3800, 4'h3);
    close_out();
  end
endmodule

// ==== wait_state_if.sv ====
/*
 * handshake between the bus sequencer and its wait-state timer.
 * assumes both ends run on the same processor clock.
 */
`timescale 1ns/1ps
interface wait_state_if;
  logic load; // start a strobe period
  logic [2:0] waits; // wait states for this access
  logic expired; // last strobe cycle
  modport ctl (output load, output waits, input expired);
  modport timer (input load, input waits, output expired);
endinterface

// ==== wait_state_timer.sv ====
/*
 * wait-state timer: counts programmed wait states of one strobe period.
 * assumes load comes from the sequencer on the edge that opens a strobe.
 */
`timescale 1ns/1ps
module wait_state_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // sequencer side
  wait_state_if.timer ws
);
  logic [2:0] count; // wait states still to run

  // reload on a new access, then count down to zero
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      count <= 3'h0;
    end else if (ws.load) begin
      count <= ws.waits;
    end else if (count != 3'h0) begin
      count <= count - 3'h1;
    end
  end

  // strobe may end once no wait states are left
  assign ws.expired = (count == 3'h0);

  property p_load_count;
    @(posedge mclk) disable iff (!resetn)
      ws.load |=> count == $past(ws.waits);
  endproperty
  a_load_count: assert property (p_load_count) else $error("wait count not loaded");
endmodule
